// ---- hw/fsag_pkg.sv ----
package fsag_pkg;

  // Register byte offsets
  localparam logic [7:0] CSR_OFFSET  = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;
  localparam logic [7:0] CSR_RESET   = 8'h00;

  // Control/status bit positions
  localparam int BIT_RDY_IE  = 7;
  localparam int BIT_BUSY    = 6;
  localparam int BIT_SIG     = 5;
  localparam int BIT_HALT    = 5;
  localparam int BIT_PROG    = 6;

  // Low-five-bit command patterns; all but CMD_NONE are accepted
  localparam logic [4:0] CMD_NONE    = 5'h00;
  localparam logic [4:0] CMD_REEN    = 5'h11;
  localparam logic [4:0] CMD_LOCKSET = 5'h09;
  localparam logic [4:0] CMD_PGWR    = 5'h05;
  localparam logic [4:0] CMD_PGER    = 5'h03;
  localparam logic [4:0] CMD_LOAD    = 5'h01;

  // Last command window count; the window spans four cycles
  localparam logic [2:0] WINDOW_LAST = 3'h3;

  // Lock field encodings
  localparam logic [1:0] LOCK_FREE = 2'h3;
  localparam logic [1:0] LOCK_ALL  = 2'h0;
  localparam logic       FUSE_UNPROG = 1'h1;

  // Lock data bit positions in the store operand
  localparam int R0_BOOT_HI = 5;
  localparam int R0_BOOT_LO = 4;
  localparam int R0_APP_HI  = 3;
  localparam int R0_APP_LO  = 2;

  localparam logic [15:0] APP_VECTOR = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_PROG  = 2'b10
  } fsag_state_t;

  function automatic logic at_or_above(input logic [15:0] a, input logic [15:0] base);
    at_or_above = (a >= base);
  endfunction : at_or_above

endpackage : fsag_pkg

// ---- hw/fsag_lock_store.sv ----
`timescale 1ns/1ns
module fsag_lock_store (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Self-programming lock set
  input  wire logic       cpu_set,
  input  wire logic [7:0] cpu_data,
  // External programming interface
  input  wire logic       ext_lock_we,
  input  wire logic [3:0] ext_lock_data,
  input  wire logic       ext_fuse_we,
  input  wire logic       ext_fuse,
  input  wire logic       chip_erase,
  // Current settings
  output logic [1:0]      app_lock,
  output logic [1:0]      boot_lock,
  output logic            boot_reset_fuse
);

  logic [1:0] app_mask;
  logic [1:0] boot_mask;

  assign app_mask  = cpu_set ? cpu_data[fsag_pkg::R0_APP_HI:fsag_pkg::R0_APP_LO]
                   : ext_lock_data[1:0];
  assign boot_mask = cpu_set ? cpu_data[fsag_pkg::R0_BOOT_HI:fsag_pkg::R0_BOOT_LO]
                   : ext_lock_data[3:2];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      app_lock        <= fsag_pkg::LOCK_FREE; // RL15
      boot_lock       <= fsag_pkg::LOCK_FREE;
      boot_reset_fuse <= fsag_pkg::FUSE_UNPROG;
    end else if (ce) begin
      if (chip_erase) begin
        app_lock  <= fsag_pkg::LOCK_FREE; // RL7
        boot_lock <= fsag_pkg::LOCK_FREE;
      end else if (cpu_set || ext_lock_we) begin
        app_lock  <= app_lock & app_mask; // RL7
        boot_lock <= boot_lock & boot_mask;
      end
      // Only the external port reaches the fuse
      if (ext_fuse_we) begin
        boot_reset_fuse <= ext_fuse; // RL17
      end
    end
  end

  chk_lock_program_only: assert property (@(posedge clk) disable iff (reset) // RL7
    (!chip_erase) |=> ((app_lock & ~$past(app_lock)) == 2'h0)
                      && ((boot_lock & ~$past(boot_lock)) == 2'h0))
    else $error("lock bit returned to unprogrammed without chip erase");

endmodule : fsag_lock_store

// ---- hw/fsag_access_check.sv ----
`timescale 1ns/1ns
module fsag_access_check (
  // Settings
  input  wire logic [1:0]  app_lock,
  input  wire logic [1:0]  boot_lock,
  input  wire logic [15:0] boot_start,
  // Core context
  input  wire logic        exec_in_boot,
  input  wire logic        vec_in_boot,
  input  wire logic [15:0] store_addr,
  input  wire logic [15:0] load_addr,
  // Verdicts
  output logic             store_ok,
  output logic             load_ok,
  output logic             int_suppress
);

  logic st_boot;
  logic ld_boot;
  logic ld_cross;

  assign st_boot  = fsag_pkg::at_or_above(store_addr, boot_start);
  assign ld_boot  = fsag_pkg::at_or_above(load_addr, boot_start);
  assign ld_cross = ld_boot != exec_in_boot;

  // Low bit programmed blocks stores; general lock levels play no part
  assign store_ok = exec_in_boot &&
                    (st_boot ? boot_lock[0] : app_lock[0]); // RL8 RL9 RL10 RL12 RL13 RL21

  // High bit programmed blocks cross-region loads
  assign load_ok = !ld_cross ||
                   (ld_boot ? boot_lock[1] : app_lock[1]); // RL8 RL9 RL10 RL12 RL13 RL21

  assign int_suppress = (!app_lock[1] && vec_in_boot && !exec_in_boot) || // RL11
                        (!boot_lock[1] && !vec_in_boot && exec_in_boot);  // RL14

endmodule : fsag_access_check

// ---- hw/fsag_top.sv ----
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Operation
// [RL1] Page program in read-while-write region keeps core running; reads only other region.
// [RL2] Region busy flag reads one while read-while-write region is blocked.
// [RL3] Software clears busy flag before using read-while-write code after programming.
// [RL4] Software avoids reading busy region; disable or move interrupt vectors.
// [RL5] Programming a no-read-while-write page halts the core for the whole operation.
// [RL6] Boot region always lies inside the no-read-while-write region.
// [RL7] Boot lock bits programmable by software or external port; only chip erase clears.
// [RL8] General memory lock levels never restrict self-programming stores or loads.
// [RL9] Application lock 11 unrestricted; 10 blocks stores into application region.
// [RL10] Application lock 00 blocks stores and boot loads; 01 blocks boot loads only.
// [RL11] Application lock 00/01 with boot vectors suppresses interrupts in application code.
// [RL12] Boot lock 11 unrestricted; 10 blocks stores into boot region.
// [RL13] Boot lock 00 blocks stores and application loads; 01 blocks those loads only.
// [RL14] Boot lock 00/01 with application vectors suppresses interrupts in boot code.
// [RL15] Lock and fuse bits: one unprogrammed, zero programmed.
// [RL16] Boot reset fuse one vectors to word zero; zero vectors to boot start.
// [RL17] Fuses change only through the external programming port, never the core.
// [RL18] Boot loader entered by jump or call, or by reset with fuse programmed.
// [RL19] Eight-bit control/status register layout as listed, all bits reset zero.
// [RL20] Busy set at read-while-write program start; cleared by re-enable or buffer load.
// [RL21] Forbidden store or load is ignored and returns no protected data.
module fsag_top #(
  parameter logic [15:0] HIGH_START = 16'h1C00,
  parameter logic [15:0] FLASH_TOP  = 16'h2000,
  parameter logic [15:0] BOOT_UNIT  = 16'h0100
) (
  // Clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Core store path
  input  wire logic        CORE_STORE_REQ,
  input  wire logic [15:0] CORE_Z_ADDR,
  input  wire logic [7:0]  CORE_R0,
  input  wire logic        CORE_EXEC_IN_BOOT,
  input  wire logic        CORE_VEC_IN_BOOT,
  // Core read path
  input  wire logic        CORE_READ_REQ,
  input  wire logic [15:0] CORE_READ_ADDR,
  input  wire logic        CORE_READ_IS_LOAD,
  output logic             READ_GRANT,
  output logic             CPU_HALT,
  output logic             INT_SUPPRESS,
  output logic [15:0]      RESET_VECTOR,
  // Flash array
  input  wire logic        FLASH_DONE,
  output logic             FLASH_ERASE_START,
  output logic             FLASH_WRITE_START,
  output logic             FLASH_LOAD_START,
  output logic [15:0]      FLASH_PAGE_ADDR,
  // External programming
  input  wire logic        EXT_LOCK_WE,
  input  wire logic [3:0]  EXT_LOCK_DATA,
  input  wire logic        EXT_FUSE_WE,
  input  wire logic        EXT_BOOT_RESET_FUSE,
  input  wire logic        EXT_CHIP_ERASE,
  input  wire logic [1:0]  BOOT_SIZE_SEL
);

  fsag_pkg::fsag_state_t state_reg;
  logic [2:0]  win_reg;
  logic [4:0]  cmd_reg;
  logic        ie_reg;
  logic        sig_reg;
  logic        busy_reg;
  logic [7:0]  awaddr_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        aw_held_reg;
  logic        w_held_reg;

  logic [1:0]  app_lock;
  logic [1:0]  boot_lock;
  logic        boot_fuse;
  logic        store_ok;
  logic        load_ok;
  logic        int_supp;

  // Boot region size and start, clamped into the no-read-while-write region
  logic [15:0] boot_size;
  logic [15:0] boot_raw;
  logic [15:0] boot_start;
  assign boot_size  = BOOT_UNIT << (2'h3 - BOOT_SIZE_SEL);
  assign boot_raw   = FLASH_TOP - boot_size;
  assign boot_start = fsag_pkg::at_or_above(boot_raw, HIGH_START)
                      ? boot_raw : HIGH_START; // RL6

  // Bus handshakes
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic b_done;
  logic r_done;
  logic aw_held_next;
  logic w_held_next;
  logic rvalid_next;
  logic do_write;
  logic csr_write;
  assign aw_hs        = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs         = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_hs        = S_AXI_ARVALID && S_AXI_ARREADY;
  assign b_done       = S_AXI_BVALID && S_AXI_BREADY;
  assign r_done       = S_AXI_RVALID && S_AXI_RREADY;
  assign aw_held_next = (aw_held_reg || aw_hs) && !b_done;
  assign w_held_next  = (w_held_reg || w_hs) && !b_done;
  assign rvalid_next  = (S_AXI_RVALID || ar_hs) && !r_done;
  assign do_write     = aw_held_reg && w_held_reg && !S_AXI_BVALID;
  assign csr_write    = do_write && wstrb0_reg && (awaddr_reg == fsag_pkg::CSR_OFFSET);

  // Read data
  logic [7:0] csr_view;
  logic [7:0] stat_view;
  logic       rd_map_ok;
  assign csr_view  = {ie_reg, busy_reg, sig_reg, cmd_reg}; // RL19 RL2
  assign stat_view = {1'h0, state_reg == fsag_pkg::ST_PROG, CPU_HALT,
                      boot_fuse, boot_lock, app_lock};
  assign rd_map_ok = (S_AXI_ARADDR == fsag_pkg::CSR_OFFSET) ||
                     (S_AXI_ARADDR == fsag_pkg::STAT_OFFSET);

  // Command decode
  logic wr_cmd_valid;
  logic store_take;
  logic op_go;
  logic op_high;
  logic load_go;
  logic reen_go;
  logic lock_go;
  logic win_expire;
  assign wr_cmd_valid = (wdata_reg[4:0] == fsag_pkg::CMD_REEN) ||
                        (wdata_reg[4:0] == fsag_pkg::CMD_LOCKSET) ||
                        (wdata_reg[4:0] == fsag_pkg::CMD_PGWR) ||
                        (wdata_reg[4:0] == fsag_pkg::CMD_PGER) ||
                        (wdata_reg[4:0] == fsag_pkg::CMD_LOAD);
  assign store_take = (state_reg == fsag_pkg::ST_ARMED) && CORE_STORE_REQ;
  assign op_go      = store_take && store_ok &&
                      ((cmd_reg == fsag_pkg::CMD_PGWR) || (cmd_reg == fsag_pkg::CMD_PGER));
  assign op_high    = fsag_pkg::at_or_above(CORE_Z_ADDR, HIGH_START);
  assign load_go    = store_take && CORE_EXEC_IN_BOOT && (cmd_reg == fsag_pkg::CMD_LOAD);
  assign reen_go    = store_take && CORE_EXEC_IN_BOOT && (cmd_reg == fsag_pkg::CMD_REEN);
  assign lock_go    = store_take && CORE_EXEC_IN_BOOT && (cmd_reg == fsag_pkg::CMD_LOCKSET);
  assign win_expire = (state_reg == fsag_pkg::ST_ARMED) && !CORE_STORE_REQ &&
                      (win_reg == fsag_pkg::WINDOW_LAST);

  // Read gating
  logic rd_in_low;
  logic grant_next;
  assign rd_in_low  = !fsag_pkg::at_or_above(CORE_READ_ADDR, HIGH_START);
  assign grant_next = CORE_READ_REQ && !CPU_HALT && // RL5
                      !(busy_reg && rd_in_low) && // RL1
                      (!CORE_READ_IS_LOAD || load_ok); // RL21

  fsag_lock_store u_locks (
    .clk             (CLK),
    .reset           (RESET),
    .ce              (CE),
    .cpu_set         (lock_go),
    .cpu_data        (CORE_R0),
    .ext_lock_we     (EXT_LOCK_WE),
    .ext_lock_data   (EXT_LOCK_DATA),
    .ext_fuse_we     (EXT_FUSE_WE),
    .ext_fuse        (EXT_BOOT_RESET_FUSE),
    .chip_erase      (EXT_CHIP_ERASE),
    .app_lock        (app_lock),
    .boot_lock       (boot_lock),
    .boot_reset_fuse (boot_fuse)
  );

  fsag_access_check u_check (
    .app_lock     (app_lock),
    .boot_lock    (boot_lock),
    .boot_start   (boot_start),
    .exec_in_boot (CORE_EXEC_IN_BOOT),
    .vec_in_boot  (CORE_VEC_IN_BOOT),
    .store_addr   (CORE_Z_ADDR),
    .load_addr    (CORE_READ_ADDR),
    .store_ok     (store_ok),
    .load_ok      (load_ok),
    .int_suppress (int_supp)
  );

  // AXI4-Lite slave
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aw_held_reg   <= 1'h0;
      w_held_reg    <= 1'h0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 8'h00;
      wstrb0_reg    <= 1'h0;
      S_AXI_AWREADY <= 1'h0;
      S_AXI_WREADY  <= 1'h0;
      S_AXI_BVALID  <= 1'h0;
      S_AXI_BRESP   <= fsag_pkg::RESP_OKAY;
      S_AXI_ARREADY <= 1'h0;
      S_AXI_RVALID  <= 1'h0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= fsag_pkg::RESP_OKAY;
    end else if (CE) begin
      aw_held_reg   <= aw_held_next;
      w_held_reg    <= w_held_next;
      S_AXI_AWREADY <= !aw_held_next;
      S_AXI_WREADY  <= !w_held_next;
      S_AXI_ARREADY <= !rvalid_next;
      S_AXI_RVALID  <= rvalid_next;
      if (aw_hs) begin
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        wdata_reg  <= S_AXI_WDATA[7:0];
        wstrb0_reg <= S_AXI_WSTRB[0];
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'h1;
        S_AXI_BRESP  <= ((awaddr_reg == fsag_pkg::CSR_OFFSET) ||
                         (awaddr_reg == fsag_pkg::STAT_OFFSET))
                        ? fsag_pkg::RESP_OKAY : fsag_pkg::RESP_SLVERR;
      end else if (b_done) begin
        S_AXI_BVALID <= 1'h0;
      end
      if (ar_hs) begin
        S_AXI_RRESP <= rd_map_ok ? fsag_pkg::RESP_OKAY : fsag_pkg::RESP_SLVERR;
        S_AXI_RDATA <= (S_AXI_ARADDR == fsag_pkg::CSR_OFFSET) ? {24'h000000, csr_view}
                     : (S_AXI_ARADDR == fsag_pkg::STAT_OFFSET) ? {24'h000000, stat_view}
                     : 32'h00000000;
      end
    end
  end

  // Command sequencer and busy flag
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_reg         <= fsag_pkg::ST_IDLE;
      win_reg           <= 3'h0;
      cmd_reg           <= fsag_pkg::CMD_NONE; // RL19
      ie_reg            <= 1'h0;
      sig_reg           <= 1'h0;
      busy_reg          <= 1'h0;
      CPU_HALT          <= 1'h0;
      FLASH_ERASE_START <= 1'h0;
      FLASH_WRITE_START <= 1'h0;
      FLASH_LOAD_START  <= 1'h0;
      FLASH_PAGE_ADDR   <= 16'h0000;
    end else if (CE) begin
      FLASH_ERASE_START <= 1'h0;
      FLASH_WRITE_START <= 1'h0;
      FLASH_LOAD_START  <= load_go;
      if (csr_write) begin
        ie_reg <= wdata_reg[fsag_pkg::BIT_RDY_IE];
      end
      case (state_reg)
        fsag_pkg::ST_IDLE, fsag_pkg::ST_ARMED: begin
          if (store_take) begin
            cmd_reg   <= fsag_pkg::CMD_NONE;
            sig_reg   <= 1'h0;
            state_reg <= fsag_pkg::ST_IDLE;
            if (op_go) begin
              cmd_reg           <= cmd_reg;
              state_reg         <= fsag_pkg::ST_PROG;
              FLASH_PAGE_ADDR   <= CORE_Z_ADDR;
              FLASH_ERASE_START <= cmd_reg == fsag_pkg::CMD_PGER;
              FLASH_WRITE_START <= cmd_reg == fsag_pkg::CMD_PGWR;
              CPU_HALT          <= op_high; // RL5
              if (!op_high) begin
                busy_reg <= 1'h1; // RL20 RL1
              end
            end else if (load_go || reen_go) begin
              busy_reg <= 1'h0; // RL20
            end
          end else if (csr_write && wr_cmd_valid) begin
            cmd_reg   <= wdata_reg[4:0];
            sig_reg   <= wdata_reg[fsag_pkg::BIT_SIG];
            win_reg   <= 3'h0;
            state_reg <= fsag_pkg::ST_ARMED;
          end else if (win_expire) begin
            cmd_reg   <= fsag_pkg::CMD_NONE;
            sig_reg   <= 1'h0;
            state_reg <= fsag_pkg::ST_IDLE;
          end else if (state_reg == fsag_pkg::ST_ARMED) begin
            win_reg <= win_reg + 3'h1;
          end
        end
        fsag_pkg::ST_PROG: begin
          if (FLASH_DONE) begin
            cmd_reg   <= fsag_pkg::CMD_NONE;
            CPU_HALT  <= 1'h0;
            state_reg <= fsag_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= fsag_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Core-facing registered outputs
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      READ_GRANT   <= 1'h0;
      INT_SUPPRESS <= 1'h0;
      RESET_VECTOR <= fsag_pkg::APP_VECTOR;
    end else if (CE) begin
      READ_GRANT   <= grant_next;
      INT_SUPPRESS <= int_supp; // RL11 RL14
      RESET_VECTOR <= boot_fuse ? fsag_pkg::APP_VECTOR : boot_start; // RL16
    end
  end

  chk_busy_on_start: assert property (@(posedge CLK) disable iff (RESET) // RL20
    (CE && op_go && !op_high) |=> busy_reg && !CPU_HALT)
    else $error("busy flag not set at read-while-write program start");

  chk_halt_on_high: assert property (@(posedge CLK) disable iff (RESET) // RL5
    (CE && op_go && op_high) |=> CPU_HALT && (state_reg == fsag_pkg::ST_PROG))
    else $error("core not halted for no-read-while-write program");

  chk_halt_holds: assert property (@(posedge CLK) disable iff (RESET) // RL5
    (CPU_HALT && !(CE && FLASH_DONE)) |=> CPU_HALT)
    else $error("halt released before flash operation finished");

  chk_low_blocked: assert property (@(posedge CLK) disable iff (RESET) // RL1
    (CE && CORE_READ_REQ && busy_reg && rd_in_low) |=> !READ_GRANT)
    else $error("busy region read was granted");

  chk_high_served: assert property (@(posedge CLK) disable iff (RESET) // RL1
    (CE && CORE_READ_REQ && !CORE_READ_IS_LOAD && !CPU_HALT && !rd_in_low)
    |=> READ_GRANT)
    else $error("read outside busy region refused");

  chk_busy_readback: assert property (@(posedge CLK) disable iff (RESET) // RL2
    (CE && ar_hs && S_AXI_ARADDR == fsag_pkg::CSR_OFFSET)
    |=> S_AXI_RVALID && (S_AXI_RDATA[fsag_pkg::BIT_BUSY] == $past(busy_reg)))
    else $error("busy flag readback mismatch");

  chk_load_clears: assert property (@(posedge CLK) disable iff (RESET) // RL20
    (CE && load_go) |=> !busy_reg ##1 (!busy_reg || !CE || FLASH_ERASE_START
                                       || FLASH_WRITE_START || $past(op_go)))
    else $error("buffer load did not clear busy flag");

  chk_window_expiry: assert property (@(posedge CLK) disable iff (RESET) // RL19
    (CE && win_expire && !csr_write)
    |=> (state_reg == fsag_pkg::ST_IDLE) && (cmd_reg == fsag_pkg::CMD_NONE))
    else $error("command bits survived an unused window");

  chk_vector_select: assert property (@(posedge CLK) disable iff (RESET) // RL16
    (CE && boot_fuse) |=> (RESET_VECTOR == fsag_pkg::APP_VECTOR))
    else $error("reset vector not at application start");

  chk_forbidden_store: assert property (@(posedge CLK) disable iff (RESET) // RL21
    (CE && store_take && !store_ok) |=> !FLASH_ERASE_START && !FLASH_WRITE_START)
    else $error("forbidden store reached the flash");

endmodule : fsag_top

// ---- test/fsag_core_model.sv ----
`timescale 1ns/1ns
module fsag_core_model (
  // Clock
  input  wire logic        clk,
  // Store path
  output logic             store_req,
  output logic [15:0]      z_addr,
  output logic [7:0]       r0,
  output logic             exec_in_boot,
  output logic             vec_in_boot,
  // Read path
  output logic             read_req,
  output logic [15:0]      read_addr,
  output logic             read_is_load,
  input  wire logic        read_grant
);
  initial begin
    store_req = 1'b0;
    z_addr = 16'h0000;
    r0 = 8'h00;
    exec_in_boot = 1'b1;
    vec_in_boot = 1'b0;
    read_req = 1'b0;
    read_addr = 16'h0000;
    read_is_load = 1'b0;
  end

  // Boot loader code issues every store
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    exec_in_boot <= 1'b1;
    z_addr <= a;
    r0 <= d;
    store_req <= 1'b1;
    @(posedge clk);
    store_req <= 1'b0;
    z_addr <= ~a;
    r0 <= ~d;
  endtask : store

  // Single read request, verdict one edge later
  task automatic read(input logic [15:0] a, output logic g);
    read_addr <= a;
    read_req <= 1'b1;
    @(posedge clk);
    read_req <= 1'b0;
    read_addr <= ~a;
    #1 g = read_grant;
    @(posedge clk);
  endtask : read
endmodule : fsag_core_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic        CLK, RESET, CE, FLASH_DONE, g;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, CORE_R0;
  logic        S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB, EXT_LOCK_DATA;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, BOOT_SIZE_SEL;
  logic        CORE_STORE_REQ, CORE_EXEC_IN_BOOT, CORE_VEC_IN_BOOT, CORE_READ_REQ;
  logic        CORE_READ_IS_LOAD, READ_GRANT, CPU_HALT, INT_SUPPRESS;
  logic [15:0] CORE_Z_ADDR, CORE_READ_ADDR, RESET_VECTOR, FLASH_PAGE_ADDR;
  logic        FLASH_ERASE_START, FLASH_WRITE_START, FLASH_LOAD_START;
  logic        EXT_LOCK_WE, EXT_FUSE_WE, EXT_BOOT_RESET_FUSE, EXT_CHIP_ERASE;
  int          fails = 0;
  int          checks_done = 0;
  int          n;
  logic [31:0] rd;

  fsag_top i_dut (
    .CLK, .RESET, .CE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .CORE_STORE_REQ, .CORE_Z_ADDR, .CORE_R0,
    .CORE_EXEC_IN_BOOT, .CORE_VEC_IN_BOOT, .CORE_READ_REQ, .CORE_READ_ADDR,
    .CORE_READ_IS_LOAD, .READ_GRANT, .CPU_HALT, .INT_SUPPRESS, .RESET_VECTOR, .FLASH_DONE,
    .FLASH_ERASE_START, .FLASH_WRITE_START, .FLASH_LOAD_START, .FLASH_PAGE_ADDR,
    .EXT_LOCK_WE, .EXT_LOCK_DATA, .EXT_FUSE_WE, .EXT_BOOT_RESET_FUSE, .EXT_CHIP_ERASE,
    .BOOT_SIZE_SEL
  );

  fsag_core_model i_core (
    .clk(CLK), .store_req(CORE_STORE_REQ), .z_addr(CORE_Z_ADDR), .r0(CORE_R0),
    .exec_in_boot(CORE_EXEC_IN_BOOT), .vec_in_boot(CORE_VEC_IN_BOOT),
    .read_req(CORE_READ_REQ), .read_addr(CORE_READ_ADDR),
    .read_is_load(CORE_READ_IS_LOAD), .read_grant(READ_GRANT)
  );

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic results();
    $display("checks %0d failures %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    if (k == 50) fails++;
    check("bresp", {30'h0, S_AXI_BRESP}, 32'h0);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    int k;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    if (k == 50) fails++;
    check(nm, S_AXI_RDATA, e);
    rd = {30'h0, S_AXI_RRESP};
  endtask : rchk

  // Store, then count flash strobes over the next cycles
  task automatic st(input logic [15:0] a, input logic [7:0] d);
    i_core.store(a, d);
    n = 0;
    repeat (4) begin
      #1 n += FLASH_ERASE_START + FLASH_WRITE_START + FLASH_LOAD_START;
      @(posedge CLK);
    end
  endtask : st

  task automatic done();
    FLASH_DONE <= 1'b1;
    @(posedge CLK);
    FLASH_DONE <= 1'b0;
    @(posedge CLK);
  endtask : done

  task automatic pulse_ext(input logic [2:0] m);
    {EXT_CHIP_ERASE, EXT_FUSE_WE, EXT_LOCK_WE} <= m;
    @(posedge CLK);
    {EXT_CHIP_ERASE, EXT_FUSE_WE, EXT_LOCK_WE} <= 3'h0;
    repeat (2) @(posedge CLK);
  endtask : pulse_ext

  task automatic t_reset();
    rchk(fsag_pkg::CSR_OFFSET, 32'h00, "csr reset");
    rchk(fsag_pkg::STAT_OFFSET, 32'h1F, "locks reset");
    rchk(8'h08, 32'h00, "unmapped data");
    check("unmapped resp", rd, {30'h0, fsag_pkg::RESP_SLVERR});
    check("vector", {16'h0, RESET_VECTOR}, 32'h0000);
  endtask : t_reset

  task automatic t_low();
    wr(fsag_pkg::CSR_OFFSET, 8'h03);
    st(16'h0100, 8'h00);
    check("low erase", n, 1);
    check("low halt", {31'h0, CPU_HALT}, 32'h0);
    rchk(fsag_pkg::CSR_OFFSET, 32'h43, "busy set");
    i_core.read(16'h0100, g);
    check("low blocked", {31'h0, g}, 32'h0);
    i_core.read(16'h1C10, g);
    check("high read", {31'h0, g}, 32'h1);
    done();
    wr(fsag_pkg::CSR_OFFSET, 8'h01);
    st(16'h0100, 8'h00);
    check("buffer load", n, 1);
    rchk(fsag_pkg::CSR_OFFSET, 32'h00, "load clear");
    wr(fsag_pkg::CSR_OFFSET, 8'h03);
    st(16'h0100, 8'h00);
    rchk(fsag_pkg::CSR_OFFSET, 32'h43, "busy again");
    done();
    wr(fsag_pkg::CSR_OFFSET, 8'h11);
    st(16'h0000, 8'h00);
    rchk(fsag_pkg::CSR_OFFSET, 32'h00, "busy clear");
    i_core.read(16'h0100, g);
    check("low back", {31'h0, g}, 32'h1);
  endtask : t_low

  task automatic t_high();
    @(posedge CLK);
    wr(fsag_pkg::CSR_OFFSET, 8'h05);
    st(16'h1C40, 8'h00);
    check("high write", n, 1);
    check("page addr", {16'h0, FLASH_PAGE_ADDR}, 32'h1C40);
    check("halted", {31'h0, CPU_HALT}, 32'h1);
    i_core.read(16'h1C10, g);
    check("none readable", {31'h0, g}, 32'h0);
    done();
    check("released", {31'h0, CPU_HALT}, 32'h0);
  endtask : t_high

  task automatic t_lock();
    wr(fsag_pkg::CSR_OFFSET, 8'h09);
    st(16'h0000, 8'h38);
    rchk(fsag_pkg::STAT_OFFSET, 32'h1E, "app lock 10");
    wr(fsag_pkg::CSR_OFFSET, 8'h03);
    st(16'h0100, 8'h00);
    check("store locked", n, 0);
    rchk(fsag_pkg::CSR_OFFSET, 32'h00, "cmd dropped");
  endtask : t_lock

  task automatic t_ext();
    EXT_LOCK_DATA <= 4'h0;
    pulse_ext(3'h1);
    i_core.exec_in_boot <= 1'b0;
    i_core.vec_in_boot <= 1'b1;
    repeat (2) @(posedge CLK);
    check("int off", {31'h0, INT_SUPPRESS}, 32'h1);
    i_core.exec_in_boot <= 1'b1;
    i_core.vec_in_boot <= 1'b0;
    i_core.read_is_load <= 1'b1;
    i_core.read(16'h0100, g);
    check("boot load app", {31'h0, g}, 32'h0);
    check("int off boot", {31'h0, INT_SUPPRESS}, 32'h1);
    @(posedge CLK);
    EXT_BOOT_RESET_FUSE <= 1'b0;
    pulse_ext(3'h2);
    check("boot vector", {16'h0, RESET_VECTOR}, 32'h1F00);
    BOOT_SIZE_SEL <= 2'h0;
    repeat (2) @(posedge CLK);
    check("clamped vector", {16'h0, RESET_VECTOR}, 32'h1C00);
    pulse_ext(3'h4);
    rchk(fsag_pkg::STAT_OFFSET, 32'h0F, "chip erase");
  endtask : t_ext

  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    results();
  end

  initial begin
    RESET = 1'b1;
    CE = 1'b1;
    FLASH_DONE = 1'b0;
    S_AXI_AWADDR = 8'h00;
    S_AXI_ARADDR = 8'h00;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hF;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h05;
    {EXT_LOCK_WE, EXT_FUSE_WE, EXT_CHIP_ERASE} = 3'h0;
    EXT_BOOT_RESET_FUSE = 1'b1;
    EXT_LOCK_DATA = 4'hF;
    BOOT_SIZE_SEL = 2'h3;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    repeat (2) @(posedge CLK);
    t_reset();
    t_low();
    t_high();
    t_lock();
    t_ext();
    results();
  end
endmodule : tb_top
